// *** amd_pkg.sv ***
// Constants, opcode map, carrier structs and state layout for the
// addressing mode decoder.
// Assumes a single core clock and a byte-wide program and data space.
package amd_pkg;

	// ----------------------------------------------------------------
	// Spaces and sizes
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS    = 8;
	localparam int PC_W             = 12;
	localparam int DATA_SPACE_BYTES = 256;
	localparam int STACK_CELLS      = 6;
	localparam int BASE_INSTR       = 40;
	localparam int ADDR_MODES       = 9;
	localparam int VALID_OPCODES    = 244;
	localparam int INSTR_CLASSES    = 6;

	// ----------------------------------------------------------------
	// Data space locations of the working registers
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_INDIRECT_POINTER_FIRST  = 8'h80;
	localparam logic [7:0] ADDR_INDIRECT_POINTER_SECOND = 8'h81;
	localparam logic [7:0] ADDR_SHORT_REG_THIRD         = 8'h82;
	localparam logic [7:0] ADDR_SHORT_REG_FOURTH        = 8'h83;

	// ----------------------------------------------------------------
	// Opcode fields
	// ----------------------------------------------------------------
	localparam int OP_COND_MSB   = 7;
	localparam int OP_DIR_BIT    = 4;
	localparam int OP_PTR_BIT    = 4;
	localparam int OP_STORE_BIT  = 3;
	localparam int OP_BITSEL_MSB = 2;
	localparam logic [2:0] CLS_INDIRECT   = 3'h7;
	localparam logic [3:0] CLS_FAR_JUMP   = 4'h8;
	localparam logic [3:0] CLS_FAR_CALL   = 4'h9;
	localparam logic [3:0] CLS_BIT_DIRECT = 4'hA;
	localparam logic [3:0] CLS_BIT_TEST   = 4'hB;
	localparam logic [3:0] CLS_SHORT      = 4'hC;
	localparam logic [3:0] CLS_MISC       = 4'hD;
	localparam logic [3:0] MISC_DIR_LOAD  = 4'h0;
	localparam logic [3:0] MISC_DIR_STORE = 4'h1;
	localparam logic [3:0] MISC_IMM_ACC   = 4'h2;
	localparam logic [3:0] MISC_IMM_MEM   = 4'h3;
	localparam logic [3:0] MISC_RETURN    = 4'h4;
	localparam logic [3:0] MISC_NOP       = 4'h5;
	localparam logic [3:0] IND_LOAD       = 4'h0;
	localparam logic [3:0] IND_STORE      = 4'h8;
	localparam logic [2:0] COND_C_SET     = 3'h0;
	localparam logic [2:0] COND_C_CLR     = 3'h1;
	localparam logic [2:0] COND_Z_SET     = 3'h2;
	localparam logic [2:0] COND_Z_CLR     = 3'h3;

	// ----------------------------------------------------------------
	// Cycle counts and reset values
	// ----------------------------------------------------------------
	localparam logic [2:0] CYC_LDST     = 3'h4;
	localparam logic [2:0] CYC_REL      = 3'h2;
	localparam logic [2:0] CYC_BIT_TEST = 3'h5;
	localparam logic [2:0] CYC_BIT_DIR  = 3'h4;
	localparam logic [2:0] CYC_FAR      = 3'h4;
	localparam logic [2:0] CYC_INHERENT = 3'h2;
	localparam logic [11:0] RST_PC      = 12'h000;
	localparam logic [7:0]  RST_ACC     = 8'h00;
	localparam logic        RST_FLAG    = 1'b0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		MODE_IMMEDIATE    = 4'h0,
		MODE_DIRECT       = 4'h1,
		MODE_SHORT_DIRECT = 4'h2,
		MODE_EXTENDED     = 4'h3,
		MODE_RELATIVE     = 4'h4,
		MODE_BIT_DIRECT   = 4'h5,
		MODE_BIT_TEST     = 4'h6,
		MODE_INDIRECT     = 4'h7,
		MODE_INHERENT     = 4'h8
	} amd_mode_e;

	typedef enum logic [3:0] {
		OPK_ILLEGAL        = 4'h0,
		OPK_MOVE_ACC_LOAD  = 4'h1,
		OPK_MOVE_ACC_STORE = 4'h2,
		OPK_MOVE_IMM_ACC   = 4'h3,
		OPK_MOVE_IMM_MEM   = 4'h4,
		OPK_FAR_JUMP       = 4'h5,
		OPK_FAR_CALL       = 4'h6,
		OPK_REL_BRANCH     = 4'h7,
		OPK_BIT_SET        = 4'h8,
		OPK_BIT_CLR        = 4'h9,
		OPK_BIT_TEST       = 4'hA,
		OPK_RETURN         = 4'hB,
		OPK_NOP            = 4'hC
	} amd_op_e;

	typedef enum logic [2:0] {
		ST_DEC = 3'h0,
		ST_B1  = 3'h1,
		ST_B2  = 3'h2,
		ST_PTR = 3'h3,
		ST_RD  = 3'h4,
		ST_WR  = 3'h5
	} amd_state_e;

	typedef struct packed {
		logic      valid;
		amd_op_e   op;
		amd_mode_e mode;
		logic [1:0] bytes;
		logic [2:0] cycles;
		logic      z_eff;
		logic      c_eff;
	} amd_info_s;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       we;
	} amd_dm_s;

	typedef struct packed {
		amd_state_e                  st;
		logic [11:0]                 pc;
		logic [7:0]                  opcode;
		logic [7:0]                  byte1;
		logic [7:0]                  byte2;
		logic [7:0]                  acc;
		logic                        z;
		logic                        c;
		logic [2:0]                  sp;
		logic [STACK_CELLS-1:0][11:0] stack;
		amd_info_s                   info;
		logic [11:0]                 pm_addr;
		amd_dm_s                     dm;
		logic                        done;
		logic                        illegal;
		logic                        int_taken;
	} amd_state_s;

endpackage : amd_pkg

// *** amd_core.sv ***
// Addressing mode decoder and load/store sequencer of the core.
// Assumes program and data memory answer in the same cycle as the address.
`timescale 1ns/1ps
// Overview of operation
// - Direct mode: byte after opcode addresses any of 256 data bytes.
// - Six-cell stack of 12-bit return addresses for calls and interrupts.
// - Immediate mode: operand is the byte after the opcode, or after the address byte for immediate-to-memory.
// - Short-direct: one-byte opcode picks a working register at 80h-83h.
// - Far jump/call target is opcode low nibble then next byte.
// - Relative branch: two condition bits, direction bit, four-bit span.
// - Taken branch lands -15..+16 from itself, else next instruction.
// - Bit-direct: opcode gives bit, next byte gives address; set or clear.
// - Bit test branch: three bytes, displacement -127..+128.
// - Indirect: opcode bit 4 selects pointer at 80h or 81h.
// - Inherent instructions are one byte, opcode alone suffices.
// - Loads and stores pair the accumulator with a data location.
// - Immediate-to-memory writes any data byte with three bytes.
// - Load/store cost 4 cycles; one, two or three bytes by mode.
// - Load/store update Z, keep C; immediate-to-memory keeps both.
// - Decoder knows 40 base instructions, nine modes, six classes.
module amd_core
	import amd_pkg::*;
#(
	parameter int          STACK_DEPTH = STACK_CELLS,
	parameter logic [11:0] INT_VECTOR  = 12'hFF0
) (
	input  wire logic        CLK_SYS_I,       // Core clock
	input  wire logic        SYS_RST_I,       // Synchronous reset, high
	input  wire logic [7:0]  PM_DATA_I,       // Program byte at PM_ADDR_O
	input  wire logic [7:0]  DM_RDATA_I,      // Data byte at DM_ADDR_O
	input  wire logic        INT_REQ_I,       // Interrupt entry request
	output logic      [11:0] PM_ADDR_O,       // Program address
	output logic      [7:0]  DM_ADDR_O,       // Data space address
	output logic      [7:0]  DM_WDATA_O,      // Data space write byte
	output logic             DM_WE_O,         // Data space write strobe
	output logic      [7:0]  ACC_O,           // Accumulator
	output logic             FLAG_Z_O,        // Zero flag
	output logic             FLAG_C_O,        // Carry flag
	output logic      [11:0] PC_O,            // Current instruction address
	output amd_info_s        INFO_O,          // Decode of current opcode
	output logic             INSTR_DONE_O,    // Instruction retired
	output logic             ILLEGAL_O,       // Unknown opcode retired
	output logic             INT_TAKEN_O,     // Interrupt entered
	output logic      [2:0]  STACK_LEVEL_O    // Stack cells in use
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (STACK_DEPTH < 1 || STACK_DEPTH > STACK_CELLS) begin : g_bad_depth
		$error("STACK_DEPTH out of range");
	end

	localparam logic [2:0] DEPTH = 3'(STACK_DEPTH);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic is_zero(input logic [7:0] v);
		return (v == 8'h00);
	endfunction : is_zero

	function automatic logic [7:0] bit_mask(input logic [2:0] idx);
		return 8'(8'h01 << idx);
	endfunction : bit_mask

	function automatic amd_info_s decode_op(input logic [7:0] op);
		amd_info_s i;
		i        = '0;
		i.valid  = 1'b1;
		i.op     = OPK_ILLEGAL;
		i.mode   = MODE_INHERENT;
		i.bytes  = 2'd1;
		i.cycles = CYC_LDST;
		if (op[OP_COND_MSB] == 1'b0) begin
			i.op     = OPK_REL_BRANCH;
			i.mode   = MODE_RELATIVE;
			i.cycles = CYC_REL;
		end else if (op[7:5] == CLS_INDIRECT) begin
			i.mode  = MODE_INDIRECT;
			i.z_eff = 1'b1;
			if (op[3:0] == IND_LOAD) begin
				i.op = OPK_MOVE_ACC_LOAD;
			end else if (op[3:0] == IND_STORE) begin
				i.op = OPK_MOVE_ACC_STORE;
			end else begin
				i.valid = 1'b0;
			end
		end else begin
			case (op[7:4])
				CLS_FAR_JUMP, CLS_FAR_CALL: begin
					i.op     = (op[7:4] == CLS_FAR_JUMP) ? OPK_FAR_JUMP : OPK_FAR_CALL;
					i.mode   = MODE_EXTENDED;
					i.bytes  = 2'd2;
					i.cycles = CYC_FAR;
				end
				CLS_BIT_DIRECT: begin
					i.op     = op[OP_STORE_BIT] ? OPK_BIT_SET : OPK_BIT_CLR;
					i.mode   = MODE_BIT_DIRECT;
					i.bytes  = 2'd2;
					i.cycles = CYC_BIT_DIR;
				end
				CLS_BIT_TEST: begin
					i.op     = OPK_BIT_TEST;
					i.mode   = MODE_BIT_TEST;
					i.bytes  = 2'd3;
					i.cycles = CYC_BIT_TEST;
					i.c_eff  = 1'b1;
				end
				CLS_SHORT: begin
					i.op    = op[OP_STORE_BIT] ? OPK_MOVE_ACC_STORE : OPK_MOVE_ACC_LOAD;
					i.mode  = MODE_SHORT_DIRECT;
					i.z_eff = 1'b1;
					i.valid = (op[2] == 1'b0);
				end
				CLS_MISC: begin
					case (op[3:0])
						MISC_DIR_LOAD, MISC_DIR_STORE: begin
							i.op    = (op[3:0] == MISC_DIR_LOAD) ? OPK_MOVE_ACC_LOAD
							                                     : OPK_MOVE_ACC_STORE;
							i.mode  = MODE_DIRECT;
							i.bytes = 2'd2;
							i.z_eff = 1'b1;
						end
						MISC_IMM_ACC: begin
							i.op    = OPK_MOVE_IMM_ACC;
							i.mode  = MODE_IMMEDIATE;
							i.bytes = 2'd2;
							i.z_eff = 1'b1;
						end
						MISC_IMM_MEM: begin
							i.op    = OPK_MOVE_IMM_MEM;
							i.mode  = MODE_IMMEDIATE;
							i.bytes = 2'd3;
						end
						MISC_RETURN: begin
							i.op     = OPK_RETURN;
							i.cycles = CYC_INHERENT;
						end
						MISC_NOP: begin
							i.op     = OPK_NOP;
							i.cycles = CYC_INHERENT;
						end
						default: begin
							i.valid = 1'b0;
						end
					endcase
				end
				default: begin
					i.valid = 1'b0;
				end
			endcase
		end
		if (!i.valid) begin
			i.op     = OPK_ILLEGAL;
			i.mode   = MODE_INHERENT;
			i.bytes  = 2'd1;
			i.cycles = CYC_INHERENT;
			i.z_eff  = 1'b0;
			i.c_eff  = 1'b0;
		end
		return i;
	endfunction : decode_op

	function automatic amd_state_s push_ret(input amd_state_s x, input logic [11:0] ra);
		amd_state_s y;
		y = x;
		if (x.sp < DEPTH) begin
			y.stack[x.sp] = ra;
			y.sp          = 3'(x.sp + 3'd1);
		end else begin
			y.stack[DEPTH-3'd1] = ra;
		end
		return y;
	endfunction : push_ret

	// Ends the instruction; a pending interrupt is entered at this boundary
	function automatic amd_state_s retire(input amd_state_s x, input logic [11:0] npc,
	                                      input logic intr);
		amd_state_s  y;
		logic [11:0] tgt;
		y   = x;
		tgt = npc;
		if (intr) begin
			y           = push_ret(y, npc);
			tgt         = INT_VECTOR;
			y.int_taken = 1'b1;
		end
		y.pc      = tgt;
		y.pm_addr = tgt;
		y.st      = ST_DEC;
		y.done    = 1'b1;
		return y;
	endfunction : retire

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	amd_state_s s_ff;
	amd_state_s nxt_s;
	amd_info_s  dec;
	logic [11:0] pc_next;
	logic [11:0] rel_tgt;
	logic [11:0] disp_tgt;
	logic        cond_ok;
	logic        ret_ok;
	logic [11:0] ret_pc;

	assign dec      = decode_op(PM_DATA_I);
	assign pc_next  = 12'(s_ff.pc + {10'h000, s_ff.info.bytes});
	assign disp_tgt = 12'(s_ff.pc + 12'd1 + {{4{s_ff.byte2[7]}}, s_ff.byte2});
	assign ret_ok   = (s_ff.sp != 3'd0);
	assign ret_pc   = ret_ok ? s_ff.stack[s_ff.sp-3'd1] : s_ff.stack[0];

	// Relative target: forward adds span plus one, backward subtracts span
	always_comb begin
		if (PM_DATA_I[OP_DIR_BIT] == 1'b0) begin
			rel_tgt = 12'(s_ff.pc + {8'h00, PM_DATA_I[3:0]} + 12'd1);
		end else begin
			rel_tgt = 12'(s_ff.pc - {8'h00, PM_DATA_I[3:0]});
		end
		case (PM_DATA_I[6:5])
			COND_C_SET[1:0]: cond_ok = s_ff.c;
			COND_C_CLR[1:0]: cond_ok = !s_ff.c;
			COND_Z_SET[1:0]: cond_ok = s_ff.z;
			COND_Z_CLR[1:0]: cond_ok = !s_ff.z;
			default:         cond_ok = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		nxt_s           = s_ff;
		nxt_s.done      = 1'b0;
		nxt_s.illegal   = 1'b0;
		nxt_s.int_taken = 1'b0;
		nxt_s.dm.we     = 1'b0;
		case (s_ff.st)
			ST_DEC: begin
				nxt_s.opcode = PM_DATA_I;
				nxt_s.info   = dec;
				case (dec.op)
					OPK_REL_BRANCH: begin
						nxt_s = retire(nxt_s, cond_ok ? rel_tgt : 12'(s_ff.pc + 12'd1),
						               INT_REQ_I);
					end
					OPK_RETURN: begin
						nxt_s.sp = ret_ok ? 3'(s_ff.sp - 3'd1) : 3'd0;
						nxt_s    = retire(nxt_s, ret_pc, INT_REQ_I);
					end
					OPK_NOP: begin
						nxt_s = retire(nxt_s, 12'(s_ff.pc + 12'd1), INT_REQ_I);
					end
					OPK_ILLEGAL: begin
						nxt_s         = retire(nxt_s, 12'(s_ff.pc + 12'd1), INT_REQ_I);
						nxt_s.illegal = 1'b1;
					end
					OPK_MOVE_ACC_LOAD, OPK_MOVE_ACC_STORE: begin
						if (dec.mode == MODE_SHORT_DIRECT) begin
							nxt_s.dm.addr = ADDR_INDIRECT_POINTER_FIRST | {6'h00, PM_DATA_I[1:0]};
							if (dec.op == OPK_MOVE_ACC_LOAD) begin
								nxt_s.st = ST_RD;
							end else begin
								nxt_s.dm.wdata = s_ff.acc;
								nxt_s.dm.we    = 1'b1;
								nxt_s.z        = is_zero(s_ff.acc);
								nxt_s.st       = ST_WR;
							end
						end else if (dec.mode == MODE_INDIRECT) begin
							nxt_s.dm.addr = PM_DATA_I[OP_PTR_BIT] ? ADDR_INDIRECT_POINTER_SECOND
							                                      : ADDR_INDIRECT_POINTER_FIRST;
							nxt_s.st      = ST_PTR;
						end else begin
							nxt_s.pm_addr = 12'(s_ff.pc + 12'd1);
							nxt_s.st      = ST_B1;
						end
					end
					default: begin
						nxt_s.pm_addr = 12'(s_ff.pc + 12'd1);
						nxt_s.st      = ST_B1;
					end
				endcase
			end
			ST_B1: begin
				nxt_s.byte1 = PM_DATA_I;
				case (s_ff.info.op)
					OPK_FAR_JUMP: begin
						nxt_s = retire(nxt_s, {s_ff.opcode[3:0], PM_DATA_I}, INT_REQ_I);
					end
					OPK_FAR_CALL: begin
						nxt_s = push_ret(nxt_s, pc_next);
						nxt_s = retire(nxt_s, {s_ff.opcode[3:0], PM_DATA_I}, INT_REQ_I);
					end
					OPK_MOVE_IMM_ACC: begin
						nxt_s.acc = PM_DATA_I;
						nxt_s.z   = is_zero(PM_DATA_I);
						nxt_s     = retire(nxt_s, pc_next, INT_REQ_I);
					end
					OPK_MOVE_IMM_MEM, OPK_BIT_TEST: begin
						nxt_s.pm_addr = 12'(s_ff.pc + 12'd2);
						nxt_s.st      = ST_B2;
					end
					OPK_MOVE_ACC_STORE: begin
						nxt_s.dm.addr  = PM_DATA_I;
						nxt_s.dm.wdata = s_ff.acc;
						nxt_s.dm.we    = 1'b1;
						nxt_s.z        = is_zero(s_ff.acc);
						nxt_s.st       = ST_WR;
					end
					default: begin
						nxt_s.dm.addr = PM_DATA_I;
						nxt_s.st      = ST_RD;
					end
				endcase
			end
			ST_B2: begin
				nxt_s.byte2   = PM_DATA_I;
				nxt_s.dm.addr = s_ff.byte1;
				if (s_ff.info.op == OPK_MOVE_IMM_MEM) begin
					nxt_s.dm.wdata = PM_DATA_I;
					nxt_s.dm.we    = 1'b1;
					nxt_s.st       = ST_WR;
				end else begin
					nxt_s.st = ST_RD;
				end
			end
			ST_PTR: begin
				nxt_s.dm.addr = DM_RDATA_I;
				if (s_ff.info.op == OPK_MOVE_ACC_LOAD) begin
					nxt_s.st = ST_RD;
				end else begin
					nxt_s.dm.wdata = s_ff.acc;
					nxt_s.dm.we    = 1'b1;
					nxt_s.z        = is_zero(s_ff.acc);
					nxt_s.st       = ST_WR;
				end
			end
			ST_RD: begin
				case (s_ff.info.op)
					OPK_MOVE_ACC_LOAD: begin
						nxt_s.acc = DM_RDATA_I;
						nxt_s.z   = is_zero(DM_RDATA_I);
						nxt_s     = retire(nxt_s, pc_next, INT_REQ_I);
					end
					OPK_BIT_SET: begin
						nxt_s.dm.wdata = DM_RDATA_I | bit_mask(s_ff.opcode[OP_BITSEL_MSB:0]);
						nxt_s.dm.we    = 1'b1;
						nxt_s.st       = ST_WR;
					end
					OPK_BIT_CLR: begin
						nxt_s.dm.wdata = DM_RDATA_I & ~bit_mask(s_ff.opcode[OP_BITSEL_MSB:0]);
						nxt_s.dm.we    = 1'b1;
						nxt_s.st       = ST_WR;
					end
					OPK_BIT_TEST: begin
						nxt_s.c = DM_RDATA_I[s_ff.opcode[OP_BITSEL_MSB:0]];
						nxt_s   = retire(nxt_s,
						                 (DM_RDATA_I[s_ff.opcode[OP_BITSEL_MSB:0]] ==
						                  s_ff.opcode[OP_STORE_BIT]) ? disp_tgt : pc_next,
						                 INT_REQ_I);
					end
					default: begin
						nxt_s = retire(nxt_s, pc_next, INT_REQ_I);
					end
				endcase
			end
			ST_WR: begin
				nxt_s = retire(nxt_s, pc_next, INT_REQ_I);
			end
			default: begin
				nxt_s.st = ST_DEC;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (SYS_RST_I) begin
			s_ff         <= '0;
			s_ff.st      <= ST_DEC;
			s_ff.pc      <= RST_PC;
			s_ff.pm_addr <= RST_PC;
			s_ff.acc     <= RST_ACC;
			s_ff.z       <= RST_FLAG;
			s_ff.c       <= RST_FLAG;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign PM_ADDR_O     = s_ff.pm_addr;
	assign DM_ADDR_O     = s_ff.dm.addr;
	assign DM_WDATA_O    = s_ff.dm.wdata;
	assign DM_WE_O       = s_ff.dm.we;
	assign ACC_O         = s_ff.acc;
	assign FLAG_Z_O      = s_ff.z;
	assign FLAG_C_O      = s_ff.c;
	assign PC_O          = s_ff.pc;
	assign INFO_O        = s_ff.info;
	assign INSTR_DONE_O  = s_ff.done;
	assign ILLEGAL_O     = s_ff.illegal;
	assign INT_TAKEN_O   = s_ff.int_taken;
	assign STACK_LEVEL_O = s_ff.sp;

endmodule : amd_core

// *** amd_core_sva.sv ***
// Checker for the addressing mode decoder core, bound to its ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module amd_core_sva
	import amd_pkg::*;
#(
	parameter int          STACK_DEPTH = STACK_CELLS,
	parameter logic [11:0] INT_VECTOR  = 12'hFF0
) (
	input wire logic        CLK_SYS_I,     // Core clock
	input wire logic        SYS_RST_I,     // Reset
	input wire logic        DM_WE_O,       // Write strobe
	input wire logic [7:0]  ACC_O,         // Accumulator
	input wire logic        FLAG_Z_O,      // Zero flag
	input wire logic        FLAG_C_O,      // Carry flag
	input wire logic [11:0] PC_O,          // Instruction address
	input wire amd_info_s   INFO_O,        // Decode
	input wire logic        INSTR_DONE_O,  // Retired
	input wire logic        ILLEGAL_O,     // Unknown opcode
	input wire logic        INT_TAKEN_O,   // Interrupt entry
	input wire logic [2:0]  STACK_LEVEL_O  // Stack depth
);
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (SYS_RST_I);
	logic ldst;
	assign ldst = INSTR_DONE_O && (INFO_O.op inside {OPK_MOVE_ACC_LOAD, OPK_MOVE_ACC_STORE,
		OPK_MOVE_IMM_ACC, OPK_MOVE_IMM_MEM});

	property p_rst;
		@(posedge CLK_SYS_I) disable iff (1'b0)
		SYS_RST_I |=> PC_O == 12'h000 && STACK_LEVEL_O == 3'h0 && !INSTR_DONE_O;
	endproperty
	a_rst: assert property (p_rst) else $error("state not cleared by reset");
	property p_we_pulse;
		DM_WE_O |=> !DM_WE_O;
	endproperty
	a_we_pulse: assert property (p_we_pulse) else $error("write strobe too long");
	property p_we_op;
		DM_WE_O |-> INFO_O.op inside {OPK_MOVE_ACC_STORE, OPK_MOVE_IMM_MEM, OPK_BIT_SET, OPK_BIT_CLR};
	endproperty
	a_we_op: assert property (p_we_op) else $error("write by a non-writing op");
	property p_ldst_cyc;
		ldst |-> INFO_O.cycles == CYC_LDST && FLAG_C_O == $past(FLAG_C_O);
	endproperty
	a_ldst_cyc: assert property (p_ldst_cyc) else $error("load/store cycles or carry");
	property p_ldst_bytes;
		ldst |-> INFO_O.bytes == ((INFO_O.mode inside {MODE_SHORT_DIRECT, MODE_INDIRECT}) ? 2'h1 :
			(INFO_O.op == OPK_MOVE_IMM_MEM) ? 2'h3 : 2'h2);
	endproperty
	a_ldst_bytes: assert property (p_ldst_bytes) else $error("load/store length");
	property p_ldst_z;
		ldst && INFO_O.op != OPK_MOVE_IMM_MEM |-> FLAG_Z_O == (ACC_O == 8'h00);
	endproperty
	a_ldst_z: assert property (p_ldst_z) else $error("zero flag wrong");
	property p_imm_mem;
		ldst && INFO_O.op == OPK_MOVE_IMM_MEM |-> $stable(FLAG_Z_O);
	endproperty
	a_imm_mem: assert property (p_imm_mem) else $error("flag changed by imm store");
	property p_rel;
		INSTR_DONE_O && INFO_O.op == OPK_REL_BRANCH && !INT_TAKEN_O |->
			12'(PC_O - $past(PC_O)) inside {[12'h000:12'h010], [12'hFF1:12'hFFF]};
	endproperty
	a_rel: assert property (p_rel) else $error("relative target out of span");
	property p_int;
		INT_TAKEN_O |-> INSTR_DONE_O && PC_O == INT_VECTOR && STACK_LEVEL_O != 3'h0;
	endproperty
	a_int: assert property (p_int) else $error("interrupt entry wrong");
	property p_lvl;
		ILLEGAL_O |-> INSTR_DONE_O && STACK_LEVEL_O <= STACK_DEPTH;
	endproperty
	a_lvl: assert property (p_lvl) else $error("illegal flag or stack level");
endmodule : amd_core_sva

// *** amd_mem_model.sv ***
// Program memory and data space seen by the core, both read in the same cycle.
// Assumes the bench preloads contents through hierarchical writes.
`timescale 1ns/1ps
module amd_mem_model (
	input  wire logic        clk_i,      // Core clock
	input  wire logic [11:0] pm_addr_i,  // Program address
	input  wire logic [7:0]  dm_addr_i,  // Data address
	input  wire logic [7:0]  dm_wdata_i, // Write byte
	input  wire logic        dm_we_i,    // Write strobe
	output logic      [7:0]  pm_data_o,  // Program byte
	output logic      [7:0]  dm_rdata_o  // Data byte
);
	logic [7:0] pm [4096];
	logic [7:0] dm [256];
	assign pm_data_o  = pm[pm_addr_i];
	assign dm_rdata_o = dm[dm_addr_i];
	// Empty program space holds no-ops
	initial begin
		foreach (pm[i]) pm[i] = 8'hD5;
		foreach (dm[i]) dm[i] = 8'h00;
	end
	always @(posedge clk_i) begin
		if (dm_we_i) begin
			dm[dm_addr_i] <= dm_wdata_i;
		end
	end
endmodule : amd_mem_model

// *** addressing_mode_decoder_bench.sv ***
// Self-checking bench: runs a small program and checks each retired instruction.
// Assumes the core and memory model of this folder.
`timescale 1ns/1ps
module addressing_mode_decoder_bench;
	import amd_pkg::*;
	logic        clk, rst, irq, irq_req, dm_we, fz, fc, done, ill, itk;
	logic [7:0]  pm_data, dm_rdata, dm_addr, dm_wdata, acc;
	logic [11:0] pm_addr, pc;
	logic [2:0]  lvl;
	amd_info_s   info;
	int          error_cnt, total_checks, cyc;

	amd_core u_dut (.CLK_SYS_I(clk), .SYS_RST_I(rst), .PM_DATA_I(pm_data), .DM_RDATA_I(dm_rdata),
		.INT_REQ_I(irq_req), .PM_ADDR_O(pm_addr), .DM_ADDR_O(dm_addr), .DM_WDATA_O(dm_wdata),
		.DM_WE_O(dm_we), .ACC_O(acc), .FLAG_Z_O(fz), .FLAG_C_O(fc), .PC_O(pc), .INFO_O(info),
		.INSTR_DONE_O(done), .ILLEGAL_O(ill), .INT_TAKEN_O(itk), .STACK_LEVEL_O(lvl));
	amd_mem_model u_mem (.clk_i(clk), .pm_addr_i(pm_addr), .dm_addr_i(dm_addr),
		.dm_wdata_i(dm_wdata), .dm_we_i(dm_we), .pm_data_o(pm_data), .dm_rdata_o(dm_rdata));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		irq_req <= irq;
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			error_cnt++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		if (error_cnt == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic put(input logic [11:0] a, input logic [7:0] b[]);
		foreach (b[i]) u_mem.pm[a + 12'(i)] = b[i];
	endtask : put
	// Expected {pc, acc, z, c, level, illegal, int, bytes, cycles}
	function automatic logic [31:0] ex(input logic [11:0] p, input logic [7:0] a,
		input logic [6:0] f, input logic [4:0] ic);
		return {p, a, f, ic};
	endfunction : ex
	// Waits for one retirement and compares the visible state
	task automatic step(input logic [31:0] e, input bit ci);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (done !== 1'b1 && n < 20);
		chk({pc, acc, fz, fc, lvl, ill, itk, ci ? {info.bytes, info.cycles} : e[4:0]}, e);
	endtask : step

	initial begin
		rst = 1'b1;
		irq = 1'b0;
		irq_req = 1'b0;
		error_cnt = 0;
		total_checks = 0;
		cyc = 0;
		#1;
		put(12'h000, '{8'hD2, 8'h00, 8'hD3, 8'h40, 8'h5A, 8'hD0, 8'h40, 8'hCB, 8'hE0, 8'hF8});
		put(12'h00A, '{8'hC2, 8'hA8, 8'h40, 8'hA1, 8'h40, 8'hB8, 8'h40, 8'h10});
		put(12'h020, '{8'h0F});
		put(12'h030, '{8'h2F, 8'h5F});
		put(12'h022, '{8'h93, 8'h00, 8'hD5, 8'h8A, 8'hBC});
		put(12'h300, '{8'hD4});
		put(12'hABC, '{8'hD0, 8'h40, 8'hD6});
		put(12'hFF0, '{8'hD3, 8'h50, 8'h00, 8'hD4});
		u_mem.dm[8'h80] = 8'h41;
		u_mem.dm[8'h81] = 8'h42;
		u_mem.dm[8'h41] = 8'h77;
		u_mem.dm[8'h50] = 8'hFF;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk({pc, acc, lvl}, 32'h0);
		step(ex(12'h002, 8'h00, 7'h40, {2'h2, CYC_LDST}), 1'b1);
		step(ex(12'h005, 8'h00, 7'h40, {2'h3, CYC_LDST}), 1'b1);
		step(ex(12'h007, 8'h5A, 7'h00, {2'h2, CYC_LDST}), 1'b1);
		step(ex(12'h008, 8'h5A, 7'h00, {2'h1, CYC_LDST}), 1'b1);
		step(ex(12'h009, 8'h77, 7'h00, {2'h1, CYC_LDST}), 1'b1);
		step(ex(12'h00A, 8'h77, 7'h00, {2'h1, CYC_LDST}), 1'b1);
		step(ex(12'h00B, 8'h00, 7'h40, {2'h1, CYC_LDST}), 1'b1);
		step(ex(12'h00D, 8'h00, 7'h40, {2'h2, CYC_BIT_DIR}), 1'b1);
		step(ex(12'h00F, 8'h00, 7'h40, {2'h2, CYC_BIT_DIR}), 1'b1);
		step(ex(12'h020, 8'h00, 7'h60, {2'h3, CYC_BIT_TEST}), 1'b1);
		step(ex(12'h030, 8'h00, 7'h60, {2'h1, CYC_REL}), 1'b1);
		step(ex(12'h031, 8'h00, 7'h60, {2'h1, CYC_REL}), 1'b1);
		step(ex(12'h022, 8'h00, 7'h60, {2'h1, CYC_REL}), 1'b1);
		step(ex(12'h300, 8'h00, 7'h64, {2'h2, CYC_FAR}), 1'b1);
		step(ex(12'h024, 8'h00, 7'h60, {2'h1, CYC_INHERENT}), 1'b1);
		step(ex(12'h025, 8'h00, 7'h60, {2'h1, CYC_INHERENT}), 1'b1);
		step(ex(12'hABC, 8'h00, 7'h60, {2'h2, CYC_FAR}), 1'b1);
		irq = 1'b1;
		step(ex(12'hFF0, 8'h59, 7'h25, {2'h2, CYC_LDST}), 1'b1);
		irq = 1'b0;
		step(ex(12'hFF3, 8'h59, 7'h24, {2'h3, CYC_LDST}), 1'b1);
		step(ex(12'hABE, 8'h59, 7'h20, {2'h1, CYC_INHERENT}), 1'b1);
		step(ex(12'hABF, 8'h59, 7'h22, 5'h00), 1'b0);
		chk({24'h0, u_mem.dm[8'h40]}, 32'h59);
		chk({24'h0, u_mem.dm[8'h83]}, 32'h5A);
		chk({24'h0, u_mem.dm[8'h42]}, 32'h77);
		chk({24'h0, u_mem.dm[8'h50]}, 32'h00);
		print_verdict();
	end
endmodule : addressing_mode_decoder_bench

bind amd_core amd_core_sva #(.STACK_DEPTH(STACK_DEPTH), .INT_VECTOR(INT_VECTOR)) u_sva (
	.CLK_SYS_I(CLK_SYS_I), .SYS_RST_I(SYS_RST_I), .DM_WE_O(DM_WE_O), .ACC_O(ACC_O),
	.FLAG_Z_O(FLAG_Z_O), .FLAG_C_O(FLAG_C_O), .PC_O(PC_O), .INFO_O(INFO_O),
	.INSTR_DONE_O(INSTR_DONE_O), .ILLEGAL_O(ILLEGAL_O), .INT_TAKEN_O(INT_TAKEN_O),
	.STACK_LEVEL_O(STACK_LEVEL_O));
